// ===== logic/vmtc_transfer.sv
`timescale 1ns/1ns
module vmtc_transfer
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire vmtc_pkg::vmtc_req_type req_data,
    output logic req_ready,
    output vmtc_pkg::vmtc_pins_type pins
);
    typedef struct packed {
        vmtc_pkg::vmtc_state_type state;
        logic [3:0] cnt;
        vmtc_pkg::vmtc_req_type req;
        vmtc_pkg::vmtc_pins_type pins;
    } vmtc_main_state_type;

    vmtc_main_state_type s;
    vmtc_main_state_type next_s;
    logic buf_valid;
    logic take;
    logic [3:0] nc;
    vmtc_pkg::vmtc_req_type buf_data;

    // Two queued requests ride out a busy sequencer
    vmtc_buffer u_buffer
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(req_valid),
        .in_data(req_data),
        .in_ready(req_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(take)
    );

    assign take = buf_valid && s.state == vmtc_pkg::VMTC_IDLE;
    assign nc = s.cnt + 4'h1;

    // One compare shared by every timed step of the sequencer
    function automatic logic at_cycle
    (
        input logic [3:0] count,
        input int target
    );
        return count == 4'(target);
    endfunction

    // Transfer sequencer; one cycle count drives every edge after the gate falls
    always_comb
    begin
        next_s = s;
        next_s.cnt = nc;
        next_s.pins.we_n = vmtc_pkg::WE_ALL_HIGH; // see [R3]
        unique case (s.state)
            vmtc_pkg::VMTC_IDLE:
            begin
                // Only array-to-shifter moves, no dummy cycle
                if (take) // see [R4]
                begin
                    next_s.req = buf_data;
                    next_s.state = vmtc_pkg::VMTC_SETUP;
                    next_s.cnt = vmtc_pkg::CNT_RST;
                    next_s.pins.transfer_output_gate_n = 1'b0; // see [R2]
                    next_s.pins.addr = {buf_data.bank, buf_data.row}; // see [R1]
                    // Each instance feeds only its own assemblers
                    next_s.pins.control_word_out = buf_data.offset; // see [R7] [R9]
                end
            end
            vmtc_pkg::VMTC_SETUP:
            begin
                if (at_cycle(nc, vmtc_pkg::GATE_SETUP_CYC))
                begin
                    next_s.pins.ras_n = 1'b0; // see [R2]
                    next_s.state = vmtc_pkg::VMTC_ROW;
                    next_s.cnt = vmtc_pkg::CNT_RST;
                end
            end
            vmtc_pkg::VMTC_ROW:
            begin
                // Start address takes the column slot
                if (at_cycle(nc, vmtc_pkg::RAS_TO_CAS_CYC))
                begin
                    next_s.pins.addr = {s.req.bank, s.req.start}; // see [R1]
                    next_s.pins.cas_n = 1'b0;
                    next_s.state = vmtc_pkg::VMTC_COLUMN;
                end
            end
            vmtc_pkg::VMTC_COLUMN:
            begin
                if (at_cycle(nc, vmtc_pkg::GATE_HOLD_CYC))
                begin
                    next_s.pins.transfer_output_gate_n = 1'b1; // see [R2]
                    next_s.state = vmtc_pkg::VMTC_TAIL;
                    next_s.cnt = vmtc_pkg::CNT_RST;
                end
            end
            vmtc_pkg::VMTC_TAIL:
            begin
                // Strobes rise only after the gate margin
                if (at_cycle(nc, vmtc_pkg::GATE_REL_CYC))
                begin
                    next_s.pins.ras_n = 1'b1; // see [R2]
                    next_s.pins.cas_n = 1'b1;
                end
                if (at_cycle(nc, vmtc_pkg::SHIFT_START_CYC) && s.req.shift_en)
                begin
                    next_s.pins.serial_shift_strobe = 1'b0; // see [R10] [R11]
                end
                // Bit count is set up well ahead of the strobe
                if (at_cycle(nc, vmtc_pkg::SHIFT_END_CYC))
                begin
                    next_s.pins.serial_shift_strobe = 1'b1; // see [R11]
                    next_s.pins.control_word_out = s.req.bitcnt; // see [R8]
                end
                if (at_cycle(nc, vmtc_pkg::DATA_STROBE_CYC))
                begin
                    next_s.pins.pixel_data_strobe = 1'b1; // see [R8]
                end
                if (at_cycle(nc, vmtc_pkg::DATA_STROBE_CYC + 1))
                begin
                    next_s.pins.pixel_data_strobe = 1'b0;
                    next_s.state = vmtc_pkg::VMTC_IDLE;
                end
            end
        endcase
    end

    // Idle pins: strobes inactive, shift strobe high
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s.state <= vmtc_pkg::VMTC_IDLE;
            s.cnt <= vmtc_pkg::CNT_RST;
            s.req <= '0;
            s.pins.ras_n <= 1'b1;
            s.pins.cas_n <= 1'b1;
            s.pins.transfer_output_gate_n <= 1'b1;
            s.pins.we_n <= vmtc_pkg::WE_ALL_HIGH;
            s.pins.addr <= vmtc_pkg::ADDR_RST;
            s.pins.control_word_out <= vmtc_pkg::CWORD_RST;
            s.pins.serial_shift_strobe <= 1'b1;
            s.pins.pixel_data_strobe <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign pins = s.pins;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // Write enables never drop, so every move is array to shifter
    a_we_held_high: assert property (pins.we_n == 4'hf) // see [R3]
        else $error("write enables left high state");

    // Gate must lead the row strobe, not follow it as in a read
    a_gate_before_ras: assert property ( // see [R2]
        $fell(pins.ras_n) |->
        !pins.transfer_output_gate_n && $past(!pins.transfer_output_gate_n))
        else $error("gate not active before row strobe fell");

    a_gate_hold_len: assert property ( // see [R2]
        $fell(pins.ras_n) |->
        !pins.transfer_output_gate_n[*7] ##1 pins.transfer_output_gate_n)
        else $error("gate hold after row strobe wrong");

    a_gate_released_first: assert property ( // see [R2]
        $rose(pins.ras_n) |->
        pins.transfer_output_gate_n && $past(pins.transfer_output_gate_n, 2)
        && $rose(pins.cas_n))
        else $error("strobes rose before gate margin");

    // Row strobe keeps read-cycle length, gate hold plus margin
    a_ras_low_len: assert property ( // see [R1]
        $fell(pins.ras_n) |-> ##8 !pins.ras_n ##1 pins.ras_n)
        else $error("row strobe low time wrong");

    a_column_is_start: assert property ( // see [R1]
        $fell(pins.cas_n) |->
        pins.addr[7:0] == s.req.start && !$past(pins.ras_n, 4))
        else $error("column slot lacks start address");

    // Bank bits must stand for the glue latch the whole gate time
    a_bank_during_gate: assert property ( // see [R1]
        !pins.transfer_output_gate_n |-> pins.addr[9:8] == s.req.bank)
        else $error("bank bits moved while gate active");

    a_offset_on_ras: assert property ( // see [R7]
        $fell(pins.ras_n) |->
        pins.control_word_out == s.req.offset)
        else $error("start offset missing at row strobe");

    a_shift_pulse_width: assert property ( // see [R10] [R11]
        $fell(pins.serial_shift_strobe) |->
        s.req.shift_en ##1 !pins.serial_shift_strobe ##1
        pins.serial_shift_strobe)
        else $error("shift strobe pulse wrong");

    // A stray low pulse would clock the selected bank's shifter
    a_shift_disabled: assert property ( // see [R10]
        !s.req.shift_en && s.state != vmtc_pkg::VMTC_IDLE |->
        pins.serial_shift_strobe)
        else $error("shift strobe pulsed while disabled");

    a_shift_after_gate: assert property ( // see [R11]
        $rose(pins.transfer_output_gate_n)
        && s.req.shift_en |-> ##5 $rose(pins.serial_shift_strobe) ##5
        $rose(pins.pixel_data_strobe))
        else $error("shift strobe to gate or data strobe spacing");

    a_bitcnt_at_pixel_data_strobe: assert property ( // see [R8]
        $rose(pins.pixel_data_strobe) |->
        pins.control_word_out == s.req.bitcnt && pins.serial_shift_strobe)
        else $error("bit count not on control word");

    // Only the first strobe belongs here, later video clocking does not
    a_data_strobe_single: assert property ( // see [R8]
        $rose(pins.pixel_data_strobe) |=> !pins.pixel_data_strobe)
        else $error("data strobe longer than one cycle");

    // Between transfers the row, column, gate and shift strobes rest at their idle levels
    a_idle_levels: assert property ( // see [R10]
        s.state == vmtc_pkg::VMTC_IDLE |->
        pins.serial_shift_strobe && pins.transfer_output_gate_n
        && pins.ras_n && pins.cas_n)
        else $error("strobes not idle between transfers");

    c_transfer_shift: cover property ($rose(pins.serial_shift_strobe));
    c_shift_skipped: cover property ($fell(pins.transfer_output_gate_n)
        && !s.req.shift_en);
    c_transfer_plain: cover property ($rose(pins.pixel_data_strobe)
        && !s.req.shift_en);
    c_buffer_full: cover property (!req_ready ##1 req_ready);
    c_back_to_back: cover property ($fell(pins.pixel_data_strobe) ##1
        $fell(pins.transfer_output_gate_n));
endmodule // vmtc_transfer

// ===== logic/vmtc_pkg.sv
// How it works
// [R1] A transfer puts the row address out first, then the shifter start address in the column slot, with read-cycle strobe order.
// [R2] The transfer gate goes active before the row strobe falls and goes inactive before both row and column strobes rise.
// [R3] All four write enables stay high through the whole transfer, marking an array-to-shifter move.
// [R4] Only array-to-shifter transfers exist, so no dummy direction-change cycle is ever issued.
// [R5] Board glue samples the transfer gate on the falling row strobe to raise the transfer pulse and clears it on the next rising row strobe.
// [R6] Board glue latches the two bank bits on the rising transfer pulse and holds them until the next transfer.
// [R7] The three-bit start offset is driven on the control word during the transfer and assemblers catch it with the transfer pulse.
// [R8] The bit count sits on the control word at the first possible pixel data strobe after a transfer.
// [R9] Each controller instance drives its own control word to its own group of four assemblers.
// [R10] The serial shift strobe is high at start and end of a transfer and pulses low only when enabled by the request.
// [R11] The low pulse lasts 40 ns, ends 90 ns after the gate goes inactive (the code uses 100 ns) and at least 90 ns before the first data strobe.
// [R12] Board glue drives the right shift clock in phase with the shift strobe and the left one inverted, for the selected bank.
// [R13] Board glue decodes the latched bank bits with the shift strobe, one of eight, into per-bank shift clocks and output enables.
// [R14] Board glue enables the selected bank's left serial output before the first data strobe.
// [R15] Board glue moves the output enable from left to right byte when the shift strobe falls after the first data strobe.
// [R16] For the enabled bank the right output enable follows the shift strobe and the left one is its inverse.
// [R17] Board glue clears its bank latch and transfer pulse flip-flop at reset.
package vmtc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Timing figures in ns
    localparam int GATE_SETUP_NS = 12;
    localparam int RAS_TO_CAS_NS = 65;
    localparam int GATE_AFTER_RAS_NS = 140;
    localparam int GATE_AFTER_CAS_NS = 55;
    localparam int GATE_BEFORE_RISE_NS = 40;
    localparam int SHIFT_LOW_NS = 40;
    localparam int SHIFT_AFTER_GATE_NS = 90;
    localparam int SHIFT_TO_DATA_NS = 90;
    // Least times, rounded up to whole cycles
    localparam int GATE_SETUP_CYC =
        (GATE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_TO_CAS_CYC =
        (RAS_TO_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_RAS_CYC =
        (GATE_AFTER_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_CAS_CYC = RAS_TO_CAS_CYC +
        (GATE_AFTER_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_HOLD_CYC =
        (GATE_RAS_CYC > GATE_CAS_CYC) ? GATE_RAS_CYC : GATE_CAS_CYC;
    localparam int GATE_REL_CYC =
        (GATE_BEFORE_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHIFT_LOW_CYC =
        (SHIFT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHIFT_END_CYC =
        (SHIFT_AFTER_GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHIFT_START_CYC = SHIFT_END_CYC - SHIFT_LOW_CYC;
    localparam int DATA_STROBE_CYC = SHIFT_END_CYC +
        (SHIFT_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Values after reset, and the buffer depth
    localparam logic [9:0] ADDR_RST = 10'h000;
    localparam logic [3:0] WE_ALL_HIGH = 4'hf;
    localparam logic [2:0] CWORD_RST = 3'h0;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [1:0] BUF_COUNT_RST = 2'h0;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef enum logic [2:0] {
        VMTC_IDLE = 3'b000,
        VMTC_SETUP = 3'b001,
        VMTC_ROW = 3'b010,
        VMTC_COLUMN = 3'b011,
        VMTC_TAIL = 3'b100
    } vmtc_state_type;

    typedef struct packed {
        logic [1:0] bank;
        logic [7:0] row;
        logic [7:0] start;
        logic [2:0] offset;
        logic [2:0] bitcnt;
        logic shift_en;
    } vmtc_req_type;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic transfer_output_gate_n;
        logic [3:0] we_n;
        logic [9:0] addr;
        logic [2:0] control_word_out;
        logic serial_shift_strobe;
        logic pixel_data_strobe;
    } vmtc_pins_type;
endpackage

// ===== logic/vmtc_buffer.sv
`timescale 1ns/1ns
module vmtc_buffer
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire vmtc_pkg::vmtc_req_type in_data,
    output logic in_ready,
    output logic out_valid,
    output vmtc_pkg::vmtc_req_type out_data,
    input wire logic out_ready
);
    typedef struct packed {
        vmtc_pkg::vmtc_req_type head;
        vmtc_pkg::vmtc_req_type tail;
        logic [1:0] count;
        logic in_ready;
        logic out_valid;
    } vmtc_buf_state_type;

    vmtc_buf_state_type s;
    vmtc_buf_state_type next_s;
    logic push;
    logic pop;

    // Flags come from flops, so in_ready and out_valid are registered
    always_comb
    begin
        next_s = s;
        push = in_valid && s.in_ready;
        pop = out_ready && s.out_valid;
        if (pop)
        begin
            next_s.head = s.tail;
        end
        if (push)
        begin
            if (s.count == 2'h0 || (s.count == 2'h1 && pop))
            begin
                next_s.head = in_data;
            end
            else
            begin
                next_s.tail = in_data;
            end
        end
        next_s.count = s.count + 2'(push) - 2'(pop);
        next_s.in_ready = next_s.count != vmtc_pkg::BUF_DEPTH;
        next_s.out_valid = next_s.count != vmtc_pkg::BUF_COUNT_RST;
    end

    // Head and tail hold data only, empty flag guards them
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.in_ready <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign in_ready = s.in_ready;
    assign out_valid = s.out_valid;
    assign out_data = s.head;
endmodule // vmtc_buffer

// ===== bench/vmtc_glue_model.sv
`timescale 1ns/1ns
module vmtc_glue_model
(
    input wire logic sys_rst,
    input wire vmtc_pkg::vmtc_pins_type pins,
    output logic transfer_pulse,
    output logic [1:0] bank_latch,
    output logic [3:0] left_bank_shift_clock_n,
    output logic [3:0] right_bank_shift_clock_n,
    output logic [3:0] left_serial_output_enable_n,
    output logic [3:0] right_serial_output_enable_n,
    output logic [2:0] start_offset,
    output logic [2:0] bit_count
);
    wire ras_n = pins.ras_n;
    wire pds = pins.pixel_data_strobe;
    wire s = pins.serial_shift_strobe;
    logic [3:0] sel;
    // Gate sampled on row strobe fall, pulse dropped on its rise
    always @(negedge ras_n or posedge ras_n or posedge sys_rst)
        if (sys_rst) transfer_pulse <= 1'b0;
        else transfer_pulse <= !ras_n && !pins.transfer_output_gate_n;
    // Bank bits held between transfers
    always @(posedge transfer_pulse or posedge sys_rst)
        if (sys_rst) bank_latch <= 2'h0;
        else bank_latch <= pins.addr[9:8];
    // Assemblers: offset on transfer pulse, count on data strobe
    always @(posedge transfer_pulse)
        start_offset <= pins.control_word_out;
    always @(posedge pds) bit_count <= pins.control_word_out;
    // Unselected banks stay inactive high, so no stray shift
    assign sel = 4'h1 << bank_latch;
    assign right_bank_shift_clock_n = s ? 4'hf : ~sel;
    assign left_bank_shift_clock_n = s ? ~sel : 4'hf;
    assign right_serial_output_enable_n = s ? 4'hf : ~sel;
    assign left_serial_output_enable_n = s ? ~sel : 4'hf;
endmodule // vmtc_glue_model

// ===== bench/tb_video_memory_transfer_cycle.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_video_memory_transfer_cycle;
    logic sys_clk = 0, sys_rst = 1, req_valid = 0, req_ready;
    vmtc_pkg::vmtc_req_type req_data = '0, e;
    vmtc_pkg::vmtc_pins_type p, pp;
    vmtc_pkg::vmtc_req_type exp_q [$];
    vmtc_pkg::vmtc_req_type rows [4] = '{
        {2'h0, 8'h12, 8'h34, 3'h5, 3'h2, 1'h1},
        {2'h1, 8'hff, 8'h00, 3'h0, 3'h7, 1'h0},
        {2'h2, 8'h00, 8'hff, 3'h7, 3'h0, 1'h1},
        {2'h3, 8'ha5, 8'h5a, 3'h3, 3'h4, 1'h1}};
    int error_cnt = 0, n_compared = 0, cyc, i;
    logic act = 0, lo_seen;
    logic [3:0] oh;
    logic tp;
    logic [1:0] bl;
    logic [3:0] lc, rc, lo, ro;
    logic [2:0] so, bc;
    vmtc_transfer dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_data(req_data), .req_ready(req_ready),
        .pins(p));
    vmtc_glue_model glue (.sys_rst(sys_rst), .pins(p), .transfer_pulse(tp),
        .bank_latch(bl), .left_bank_shift_clock_n(lc),
        .right_bank_shift_clock_n(rc), .left_serial_output_enable_n(lo),
        .right_serial_output_enable_n(ro), .start_offset(so),
        .bit_count(bc));
    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;
    // Pin monitor, sampled at the falling edge when pins are settled
    always @(negedge sys_clk)
    begin
        if (sys_rst) act = 0;
        else
        begin
            `CHK(p.we_n, 4'hf)
            if (pp.transfer_output_gate_n && !p.transfer_output_gate_n)
            begin
                `CHK(exp_q.size() > 0, 1'b1)
                e = exp_q[0];
                oh = 4'h1 << e.bank;
                act = 1; cyc = 0; lo_seen = 0;
                `CHK(p.serial_shift_strobe, 1'b1)
            end
            else if (act) cyc++;
            if (act && pp.ras_n && !p.ras_n)
            begin
                `CHK(cyc, 1)
                `CHK(p.addr, {e.bank, e.row})
                `CHK(p.control_word_out, e.offset)
            end
            if (act && pp.cas_n && !p.cas_n)
            begin
                `CHK(cyc, 5)
                `CHK(p.addr, {e.bank, e.start})
                `CHK(tp, 1'b1)
            end
            if (act && !pp.transfer_output_gate_n && p.transfer_output_gate_n)
                `CHK(cyc, 8)
            if (act && !pp.ras_n && p.ras_n)
            begin
                `CHK(cyc, 10)
                `CHK(p.cas_n, 1'b1)
                `CHK(tp, 1'b0)
            end
            if (act && pp.serial_shift_strobe && !p.serial_shift_strobe)
            begin
                `CHK(e.shift_en, 1'b1)
                `CHK(cyc, 11)
                `CHK({rc, ro, lo}, {~oh, ~oh, 4'hf})
            end
            if (act && !pp.serial_shift_strobe && p.serial_shift_strobe)
            begin
                `CHK(cyc, 13)
                lo_seen = 1;
            end
            if (act && !pp.pixel_data_strobe && p.pixel_data_strobe)
            begin
                `CHK(cyc, 18)
                `CHK(lo_seen, e.shift_en)
                `CHK(p.control_word_out, e.bitcnt)
                `CHK({bc, so, bl}, {e.bitcnt, e.offset, e.bank})
                `CHK({lc, lo, ro}, {~oh, ~oh, 4'hf})
                void'(exp_q.pop_front());
                act = 0;
            end
        end
        pp = p;
    end
    // Offer one request and hold it until taken; valid stays up
    task automatic send(input vmtc_pkg::vmtc_req_type r);
        int n = 0;
        req_valid = 1;
        req_data = r;
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        exp_q.push_back(r);
        @(negedge sys_clk);
    endtask
    task automatic wait_idle();
        int n = 0;
        while (exp_q.size() != 0 && n < 500)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(exp_q.size(), 0)
    endtask
    // Quiet levels expected during and right after reset
    task automatic chk_rst();
        `CHK({p.ras_n, p.cas_n, p.transfer_output_gate_n}, 3'h7)
        `CHK({p.serial_shift_strobe, p.pixel_data_strobe}, 2'h2)
        `CHK({p.addr, p.control_word_out, req_ready}, 14'h0001)
        `CHK({tp, bl}, 3'h0)
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog, ten thousand cycles, far beyond the few hundred needed
    initial
    begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    // Table rows one by one, then back to back, then reset mid-transfer
    initial
    begin
        // Fresh rising reset edge so the glue's async clears fire
        #5 sys_rst = 0;
        #1 sys_rst = 1;
        repeat (10) @(negedge sys_clk);
        chk_rst();
        sys_rst = 0;
        @(negedge sys_clk);
        chk_rst();
        for (i = 0; i < 4; i++)
        begin
            send(rows[i]);
            req_valid = 0;
            wait_idle();
        end
        for (i = 0; i < 3; i++) send(rows[i]);
        `CHK(req_ready, 1'b0)
        send(rows[3]);
        req_valid = 0;
        wait_idle();
        send(rows[3]);
        req_valid = 0;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1;
        exp_q.delete();
        @(negedge sys_clk);
        chk_rst();
        sys_rst = 0;
        send(rows[2]);
        req_valid = 0;
        wait_idle();
        print_verdict();
    end
endmodule // tb_video_memory_transfer_cycle
